// ---- src/tsq_pkg.sv ----
package tsq_pkg;

   // ---------------------------------------------------------------
   // serial frame and conversion counts
   // ---------------------------------------------------------------
   localparam int unsigned CMD_BITS       = 8;
   localparam int unsigned RES_BITS       = 12;
   localparam int unsigned FIFO_DEPTH     = 8;
   localparam logic [4:0]  ACQ_FIRST_FALL = 5'h05;
   localparam logic [4:0]  ACQ_LAST_FALL  = 5'h08;
   localparam logic [4:0]  MSB_FALL       = 5'h09;
   localparam logic [4:0]  LSB_FALL       = 5'h14;
   localparam logic [4:0]  CMD_LAST_RISE  = 5'h07;

   // ---------------------------------------------------------------
   // command word bit positions, full word received
   // ---------------------------------------------------------------
   localparam int unsigned CMD_REF_POS    = 2;
   localparam int unsigned CMD_PD0_POS    = 0;

   // ---------------------------------------------------------------
   // converter input sources, one bit each
   // ---------------------------------------------------------------
   localparam int unsigned SRC_TEMP   = 0;
   localparam int unsigned SRC_XP     = 1;
   localparam int unsigned SRC_YP     = 2;
   localparam int unsigned SRC_XN     = 3;
   localparam int unsigned SRC_YN     = 4;
   localparam int unsigned SRC_SUPPLY = 5;
   localparam int unsigned SRC_AUX    = 6;
   localparam int unsigned SRC_COUNT  = 7;

   // panel drivers {xp, xn, yp, yn}
   localparam logic [3:0] DRV_NONE  = 4'h0;
   localparam logic [3:0] DRV_Y     = 4'h3;
   localparam logic [3:0] DRV_X     = 4'hC;
   localparam logic [3:0] DRV_PRESS = 4'h6;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_CMD  = 4'h2,
      ST_CONV = 4'h4,
      ST_DONE = 4'h8
   } tsq_state_type;

endpackage

// ---- src/tsq_stream_if.sv ----
interface tsq_stream_if #(parameter int unsigned WIDTH = 12);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- src/tsq_fifo.sv ----
module tsq_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = tsq_pkg::FIFO_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   tsq_stream_if.snk        wr,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } tsq_fifo_state_type;

   tsq_fifo_state_type q;
   tsq_fifo_state_type d;
   logic               push;
   logic               pop;

   // ---------------------------------------------------------------
   // flags and next state
   // ---------------------------------------------------------------
   assign wr.ready = (q.cnt != (AW+1)'(DEPTH));
   assign rd_valid = (q.cnt != '0);
   assign rd_data  = q.mem[q.rp];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd_valid && rd_ready;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = wr.data;
         d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
      end
      if (pop)
         d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
      if (push && !pop)
         d.cnt = q.cnt + 1'b1;
      else if (pop && !push)
         d.cnt = q.cnt - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end
endmodule

// ---- src/tsq_sequencer.sv ----
// Overview of operation
// - The serial input is taken on rising shift clock edges until the command word is complete.
// - Input bits are taken only with chip select low, never with it high.
// - The serial output changes only on falling shift clock edges, and is cleared while chip select is high.
// - With chip select high, serial output and busy are high impedance.
// - Busy is high for one shift clock period before the first decision.
// - The input is sampled from the fifth to the eighth fall, then converted if the result buffer has room.
// - All shifting and conversion is paced by the host shift clock alone.
// - Successive approximation resolves one bit per step, 12 bits in all.
// - At most one source at a time is routed to the converter input.
// - Single-ended uses the reference pin; differential the driven pair.
// - The pen interrupt is only ever driven low and is otherwise released.
// - A three-bit channel field picks the converter input and drivers.
// - The reference-mode bit picks single-ended at 1, differential at 0.
// - If enabled, touch with chip select high pulls the pen interrupt low.
module tsq_sequencer #(
   parameter int unsigned RES_W = tsq_pkg::RES_BITS
) (
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic                           shift_clock,
   input  wire logic                           cs_n,
   input  wire logic                           din,
   output logic                                dout,
   output logic                                dout_oe_n,
   output logic                                busy,
   output logic                                busy_oe_n,
   input  wire logic                           touch_sense,
   output logic                                touch_irq_n,
   output logic                                touch_irq_oe_n,
   output logic [tsq_pkg::SRC_COUNT-1:0]       mux_src,
   output logic [3:0]                          panel_drv,
   output logic                                ref_diff,
   output logic [RES_W-1:0]                    sar_trial,
   input  wire logic                           comp_hi,
   output logic                                res_valid,
   input  wire logic                           res_ready,
   output logic [RES_W-1:0]                    res_data
);
   typedef struct packed {
      tsq_pkg::tsq_state_type st;
      logic                   sclk_prev;
      logic [7:0]             cmd;
      logic [4:0]             fall_cnt;
      logic [2:0]             chan;
      logic                   ref_se;
      logic                   pen_en;
      logic [RES_W-1:0]       res;
      logic                   dout;
      logic                   busy;
      logic                   irq_drv;
      logic                   push;
   } tsq_seq_state_type;

   localparam tsq_seq_state_type RST = '{
      st: tsq_pkg::ST_IDLE, sclk_prev: 1'b0, cmd: 8'h00, fall_cnt: 5'h00,
      chan: 3'h0, ref_se: 1'b1, pen_en: 1'b1, res: '0, dout: 1'b0,
      busy: 1'b0, irq_drv: 1'b0, push: 1'b0};

   tsq_seq_state_type q;
   tsq_seq_state_type d;
   logic              rise;
   logic              fall;
   logic              active;
   logic [4:0]        bit_cur;
   logic [4:0]        bit_nxt;

   tsq_stream_if #(.WIDTH(RES_W)) push_if ();

   // ---------------------------------------------------------------
   // source and driver decode
   // ---------------------------------------------------------------
   function automatic logic [tsq_pkg::SRC_COUNT-1:0] src_of(
      input logic [2:0] ch, input logic se);
      logic [tsq_pkg::SRC_COUNT-1:0] s;
      s = '0;
      unique case (ch)
         3'h1, 3'h3: s[tsq_pkg::SRC_XP] = 1'b1;
         3'h2: s[se ? tsq_pkg::SRC_SUPPLY : tsq_pkg::SRC_YN] = 1'b1;
         3'h4: s[tsq_pkg::SRC_YN] = 1'b1;
         3'h5: s[tsq_pkg::SRC_YP] = 1'b1;
         3'h6: s[tsq_pkg::SRC_AUX] = 1'b1;
         3'h0, 3'h7: s[tsq_pkg::SRC_TEMP] = 1'b1;
      endcase
      return s;
   endfunction

   function automatic logic [3:0] drv_of(
      input logic [2:0] ch, input logic se);
      logic [3:0] r;
      r = tsq_pkg::DRV_NONE;
      unique case (ch)
         3'h1: r = tsq_pkg::DRV_Y;
         3'h3, 3'h4: r = tsq_pkg::DRV_PRESS;
         3'h5: r = tsq_pkg::DRV_X;
         3'h2: r = se ? tsq_pkg::DRV_NONE : tsq_pkg::DRV_PRESS;
         3'h0, 3'h6, 3'h7: r = tsq_pkg::DRV_NONE;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // edge detect and outputs
   // ---------------------------------------------------------------
   assign rise    = shift_clock && !q.sclk_prev;
   assign fall    = !shift_clock && q.sclk_prev;
   assign active  = (q.st == tsq_pkg::ST_CONV) ||
                    ((q.st == tsq_pkg::ST_CMD) &&
                     (q.fall_cnt >= tsq_pkg::ACQ_FIRST_FALL));
   assign bit_cur = 5'(tsq_pkg::LSB_FALL - q.fall_cnt - 5'h01);
   assign bit_nxt = 5'(tsq_pkg::LSB_FALL - q.fall_cnt - 5'h01);

   assign dout           = q.dout;
   assign dout_oe_n      = cs_n;
   assign busy           = q.busy;
   assign busy_oe_n      = cs_n;
   assign touch_irq_n    = 1'b0;
   assign touch_irq_oe_n = !q.irq_drv;
   assign mux_src   = active ? src_of(q.chan, q.ref_se) : '0;
   assign panel_drv = active ? drv_of(q.chan, q.ref_se) : '0;
   assign ref_diff  = active && !q.ref_se;
   assign sar_trial = (q.st == tsq_pkg::ST_CONV) ?
                      (q.res | (RES_W'(1) << bit_cur[3:0])) : '0;
   assign push_if.valid = q.push;
   assign push_if.data  = q.res;

   // ---------------------------------------------------------------
   // sequencer next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.sclk_prev = shift_clock;
      d.push = 1'b0;
      d.irq_drv = q.pen_en && touch_sense && cs_n;
      if (cs_n)
      begin
         d.st = tsq_pkg::ST_IDLE;
         d.fall_cnt = 5'h00;
         d.dout = 1'b0;
         d.busy = 1'b0;
      end
      else
      begin
         unique case (q.st)
            tsq_pkg::ST_IDLE:
            begin
               if (rise && din)
               begin
                  d.st = tsq_pkg::ST_CMD;
                  d.cmd = 8'h01;
                  d.fall_cnt = 5'h00;
               end
            end
            tsq_pkg::ST_CMD:
            begin
               if (rise && q.fall_cnt <= tsq_pkg::CMD_LAST_RISE)
                  d.cmd = {q.cmd[6:0], din};
               if (fall)
               begin
                  d.fall_cnt = q.fall_cnt + 5'h01;
                  if (d.fall_cnt == tsq_pkg::ACQ_FIRST_FALL)
                     d.chan = q.cmd[3:1];
                  if (d.fall_cnt == tsq_pkg::ACQ_FIRST_FALL + 5'h01)
                     d.ref_se = q.cmd[0];
                  if (d.fall_cnt == tsq_pkg::ACQ_LAST_FALL)
                  begin
                     d.pen_en = !q.cmd[tsq_pkg::CMD_PD0_POS];
                     d.ref_se = q.cmd[tsq_pkg::CMD_REF_POS];
                     d.res = '0;
                     if (push_if.ready)
                     begin
                        d.st = tsq_pkg::ST_CONV;
                        d.busy = 1'b1;
                     end
                     else
                        d.st = tsq_pkg::ST_DONE;
                  end
               end
            end
            tsq_pkg::ST_CONV:
            begin
               if (fall)
               begin
                  d.fall_cnt = q.fall_cnt + 5'h01;
                  d.busy = 1'b0;
                  d.res[bit_nxt[3:0]] = comp_hi;
                  d.dout = comp_hi;
                  if (d.fall_cnt == tsq_pkg::LSB_FALL)
                  begin
                     d.push = 1'b1;
                     d.st = tsq_pkg::ST_DONE;
                  end
               end
            end
            tsq_pkg::ST_DONE:
            begin
               if (fall)
                  d.dout = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= RST;
      else
         q <= d;
   end

   // ---------------------------------------------------------------
   // result buffer
   // ---------------------------------------------------------------
   tsq_fifo #(
      .WIDTH (RES_W),
      .DEPTH (tsq_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .wr       (push_if.snk),
      .rd_valid (res_valid),
      .rd_ready (res_ready),
      .rd_data  (res_data)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   cs_ignore_a: assert property (cs_n |=> q.st == tsq_pkg::ST_IDLE)
      else $error("sequencer active with chip select high");
   dout_on_fall_a: assert property ($changed(dout) |->
      $past(fall) || $past(cs_n))
      else $error("serial output moved off a falling edge");
   release_on_cs_a: assert property (cs_n |-> dout_oe_n && busy_oe_n)
      else $error("outputs driven with chip select high");
   busy_start_a: assert property ($rose(busy) |->
      q.fall_cnt == tsq_pkg::ACQ_LAST_FALL && q.st == tsq_pkg::ST_CONV)
      else $error("busy raised at wrong step");
   busy_one_period_a: assert property (busy && !cs_n |=>
      busy == !$past(fall))
      else $error("busy not one shift clock period");
   acq_window_a: assert property ((q.st == tsq_pkg::ST_CMD) &&
      (mux_src != '0) |-> q.fall_cnt >= tsq_pkg::ACQ_FIRST_FALL &&
      q.fall_cnt < tsq_pkg::ACQ_LAST_FALL)
      else $error("sampling outside fifth to eighth fall");
   push_at_lsb_a: assert property (q.push |->
      q.fall_cnt == tsq_pkg::LSB_FALL && $past(q.st) == tsq_pkg::ST_CONV)
      else $error("result stored at wrong step");
   one_source_a: assert property ($onehot0(mux_src))
      else $error("more than one converter source");
   ref_mode_a: assert property ((q.st == tsq_pkg::ST_CONV) |->
      ref_diff == !q.cmd[tsq_pkg::CMD_REF_POS])
      else $error("reference selection wrong");
   irq_touch_a: assert property (!touch_irq_oe_n |->
      touch_irq_n == 1'b0 && $past(cs_n) && $past(touch_sense))
      else $error("pen interrupt driven without touch");
   msb_first_a: assert property ((q.st == tsq_pkg::ST_CONV) && fall &&
      !cs_n |=> dout == q.res[bit_cur[3:0] + 4'h1])
      else $error("serial output not the decided bit");
endmodule

// ---- sim/tsq_host_model.sv ----
// ----
// host serial master
// ----
module tsq_host_model (
   input  wire logic clk,
   output logic      shift_clock,
   output logic      cs_n,
   output logic      din,
   input  wire logic sdo,
   input  wire logic busy_w
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      shift_clock = 1'b0;
      cs_n        = 1'b1;
      din         = 1'b0;
   end

   // h is clk cycles per half period, larger for slow sources
   task automatic frame(input logic [7:0] cmd, input int n, input int h,
                        output logic [11:0] word, output logic [24:0] bsy);
      word = '0;
      bsy  = '0;
      @(negedge clk);
      cs_n <= 1'b0;
      for (int i = 1; i <= n; i++)
      begin
         din <= (i <= 8) ? cmd[8-i] : 1'b0;
         repeat (h) @(negedge clk);
         bsy[i] = busy_w;
         if (i >= 10 && i <= 21)
            word[21-i] = sdo;
         shift_clock <= 1'b1;
         repeat (h) @(negedge clk);
         shift_clock <= 1'b0;
      end
      repeat (h) @(negedge clk);
      cs_n <= 1'b1;
   endtask

   // edges with chip select high
   task automatic idle_clocks(input int n, input int h);
      for (int i = 0; i < n; i++)
      begin
         din <= 1'b1;
         repeat (h) @(negedge clk);
         shift_clock <= 1'b1;
         repeat (h) @(negedge clk);
         shift_clock <= 1'b0;
      end
      din <= 1'b0;
   endtask
endmodule

// ---- sim/tb_touch_adc_serial_sequencer.sv ----
// ----
// sequencer bench
// ----
module tb_touch_adc_serial_sequencer;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [2:0] DIFF_CH [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
   logic        clk, rst_n, sck, cs_n, din, dout, dout_oe_n, busy;
   logic        busy_oe_n, touch_sense, touch_irq_n, touch_irq_oe_n;
   logic        comp_hi, res_valid, res_ready, ref_diff;
   logic        flip_q = 1'b0;
   logic        sdo_w, busy_w, irq_w;
   logic [6:0]  mux_src;
   logic [3:0]  panel_drv;
   logic [11:0] sar_trial, res_data, vin, word;
   logic [24:0] bsy;
   logic [15:0] lfsr;
   logic [11:0] exp_q[$];
   int          num_errors, n_tests;
   int          cyc = 0;

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      flip_q <= ~flip_q;
      cyc    <= cyc + 1;
      if (cyc == 50000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   assign comp_hi = (vin >= sar_trial);
   assign sdo_w   = dout_oe_n ? flip_q : dout;
   assign busy_w  = busy_oe_n ? ~flip_q : busy;
   assign irq_w   = touch_irq_oe_n ? 1'b1 : touch_irq_n;

   tsq_host_model i_host (.clk(clk), .shift_clock(sck), .cs_n(cs_n),
      .din(din), .sdo(sdo_w), .busy_w(busy_w));

   tsq_sequencer i_dut (.clk(clk), .rst_n(rst_n), .shift_clock(sck),
      .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
      .busy(busy), .busy_oe_n(busy_oe_n), .touch_sense(touch_sense),
      .touch_irq_n(touch_irq_n), .touch_irq_oe_n(touch_irq_oe_n),
      .mux_src(mux_src), .panel_drv(panel_drv), .ref_diff(ref_diff),
      .sar_trial(sar_trial), .comp_hi(comp_hi), .res_valid(res_valid),
      .res_ready(res_ready), .res_data(res_data));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [6:0] exp_src(input logic [2:0] ch,
                                          input logic se);
      case (ch)
         3'h1, 3'h3: return 7'h02;
         3'h2: return se ? 7'h20 : 7'h10;
         3'h4: return 7'h10;
         3'h5: return 7'h04;
         3'h6: return 7'h40;
         default: return 7'h01;
      endcase
   endfunction

   function automatic logic [3:0] exp_drv(input logic [2:0] ch,
                                          input logic se);
      case (ch)
         3'h1: return 4'h3;
         3'h2: return se ? 4'h0 : 4'h6;
         3'h3, 3'h4: return 4'h6;
         3'h5: return 4'hC;
         default: return 4'h0;
      endcase
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conv(input logic [2:0] ch, input logic se,
                       input logic pd0, input int h, input logic ok);
      logic [11:0] w;
      logic [24:0] b;
      lfsr = lfsr_next(lfsr);
      vin <= lfsr[11:0];
      fork
         i_host.frame({1'b1, ch, 1'b0, se, 1'b0, pd0}, 24, h, w, b);
         if (ok)
         begin
            for (int k = 0; k < 800 && busy !== 1'b1; k++)
               @(negedge clk);
            check(mux_src, exp_src(ch, se));
            check(panel_drv, exp_drv(ch, se));
            check(ref_diff, !se);
         end
      join
      @(negedge clk);
      check(b[10:8], ok ? 3'h2 : 3'h0);
      check(w, ok ? lfsr[11:0] : 12'h000);
      check({dout_oe_n, busy_oe_n, mux_src}, 9'h180);
      if (ok)
         exp_q.push_back(lfsr[11:0]);
   endtask

   task automatic drain();
      res_ready <= 1'b1;
      while (exp_q.size() > 0)
      begin
         check(res_data, exp_q.pop_front());
         @(negedge clk);
      end
      res_ready <= 1'b0;
      check(res_valid, 1'b0);
   endtask

   task automatic print_verdict();
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      rst_n = 1'b0;
      touch_sense = 1'b0;
      res_ready = 1'b0;
      vin = 12'h000;
      lfsr = 16'h000B;
      num_errors = 0;
      n_tests = 0;
      repeat (10) @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check({mux_src, res_valid, irq_w}, 9'h001);
      for (int c = 0; c < 8; c++)
         conv(c[2:0], 1'b1, 1'b0, 2 + c % 3, 1'b1);
      check(res_valid, 1'b1);
      conv(3'h1, 1'b0, 1'b0, 2, 1'b0);
      drain();
      for (int c = 0; c < 4; c++)
         conv(DIFF_CH[c], 1'b0, 1'b0, 3, 1'b1);
      drain();
      for (int r = 0; r < 6; r++)
      begin
         lfsr = lfsr_next(lfsr);
         conv(lfsr[2:0], 1'b1, 1'b0, 2 + lfsr[4:3], 1'b1);
      end
      drain();
      i_host.idle_clocks(10, 2);
      i_host.frame(8'hD4, 12, 2, word, bsy);
      repeat (4) @(negedge clk);
      check(res_valid, 1'b0);
      conv(3'h5, 1'b1, 1'b0, 8, 1'b1);
      drain();
      touch_sense <= 1'b1;
      repeat (4) @(negedge clk);
      check({irq_w, touch_irq_n}, 2'h0);
      touch_sense <= 1'b0;
      conv(3'h3, 1'b0, 1'b1, 2, 1'b1);
      touch_sense <= 1'b1;
      repeat (4) @(negedge clk);
      check(irq_w, 1'b1);
      drain();
      print_verdict();
   end
endmodule
